/* verilog/fatal_error_params.svh */
/*
  Constants of the fatal error communication state control: control word
  fields, status word bits and reset values.
  Assumes inclusion by bare name from the package and the state control module.
*/
`ifndef FATAL_ERROR_PARAMS_SVH
`define FATAL_ERROR_PARAMS_SVH

`define CTRL_WORD_RESET     16'h0000
`define CTRL_REACTION_BIT   0
`define CTRL_POLICY_LSB     1
`define CTRL_POLICY_MSB     2
`define STAT_WORD_RESET     16'h0000
`define STAT_WAIT_MINE_BIT  0
`define STAT_WAIT_OTHER_BIT 1
`define STAT_WAIT_RESET_BIT 2

`endif

/* verilog/fatal_error_pkg.sv */
/*
  Types shared by the fatal error communication state control.
  Assumes the params header sits in the include path.
*/
`default_nettype none
`include "fatal_error_params.svh"

package fatal_error_pkg;
  typedef enum logic [1:0] {
    POL_IMMEDIATE,
    POL_WAIT_DISABLE,
    POL_WAIT_RESET,
    POL_RESERVED
  } policy_t;

  typedef enum logic [1:0] {
    ST_SAFE_OP,
    ST_OP,
    ST_ERR_SAFE_OP
  } comm_state_t;
endpackage : fatal_error_pkg

`default_nettype wire

/* verilog/channel_if.sv */
/*
  Per-channel carrier between the state control and its channel latches.
  Assumes one instance per axis channel, all on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface channel_if;
  import fatal_error_pkg::*;
  logic    fatal_in;
  logic    clear;
  policy_t policy;
  logic    in_op;
  logic    other_enabled;
  logic    latched;
  logic    wait_other;
  logic    wait_reset;

  modport ctrl (output fatal_in, clear, policy, in_op, other_enabled,
                input  latched, wait_other, wait_reset);
  modport unit (input  fatal_in, clear, policy, in_op, other_enabled,
                output latched, wait_other, wait_reset);
endinterface : channel_if

`default_nettype wire

/* verilog/fatal_channel.sv */
/*
  Sticky fatal error latch of one axis channel and its pending flags.
  Assumes fatal_in comes from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module fatal_channel (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  channel_if.unit  ch
);
  import fatal_error_pkg::*;

  logic latched_r;
  logic latched_nxt;

  // Set wins over clear, so a fresh error is never lost
  always_comb begin
    latched_nxt = (latched_r & ~ch.clear) | ch.fatal_in;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latched_r <= 1'b0;
    end else if (ce) begin
      latched_r <= latched_nxt;
    end
  end

  assign ch.latched    = latched_r;
  // Pending flags only exist while Operational; leaving it drops them
  assign ch.wait_other = latched_r & ch.in_op & (ch.policy == POL_WAIT_DISABLE) & ch.other_enabled;
  assign ch.wait_reset = latched_r & ch.in_op & (ch.policy == POL_WAIT_RESET);
endmodule : fatal_channel

`default_nettype wire

/* verilog/fatal_error_comm_ctrl.sv */
/*
  Decides when a fatal axis error moves the shared fieldbus slave state
  from Operational to error-flagged Safe-Operational, per policy.
  Assumes all inputs come from logic on ref_clk; the control word is
  written and both status words read by the parameter channel.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fatal_error_params.svh"

module fatal_error_comm_ctrl #(
  parameter int CHANNELS = 2
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        ctrl_wr,
  input  wire logic [15:0]                 ctrl_wdata,
  output logic      [15:0]                 ctrl_rdata,
  output logic      [15:0]                 status_word_0,
  output logic      [15:0]                 status_word_1,
  input  wire logic [1:0]                  fatal_err,
  input  wire logic [1:0]                  chan_enabled,
  input  wire logic                        op_request,
  input  wire logic                        reset_cmd,
  output logic                             reset_refused,
  output fatal_error_pkg::comm_state_t     comm_state,
  output logic                             comm_error_flag,
  output logic                             actual_valid,
  output logic      [1:0]                  axis_stop
);
  import fatal_error_pkg::*;

  channel_if chif [CHANNELS] ();

  logic [15:0]  ctrl_r, ctrl_nxt;
  logic [15:0]  stat_r [2];
  logic [15:0]  stat_nxt [2];
  logic         refused_r, refused_nxt;
  comm_state_t  state_r, state_nxt;
  policy_t      policy;
  logic [1:0]   latched, wait_other, wait_reset, disable_trig;
  logic         any_latched, lock, reset_ok, trig;

  function automatic logic [15:0] status_of(input logic w_mine, input logic w_other, input logic w_reset);
    logic [15:0] s;
    s = `STAT_WORD_RESET;
    s[`STAT_WAIT_MINE_BIT]  = w_mine;
    s[`STAT_WAIT_OTHER_BIT] = w_other;
    s[`STAT_WAIT_RESET_BIT] = w_reset;
    return s;
  endfunction : status_of

  assign policy = policy_t'(ctrl_r[`CTRL_POLICY_MSB:`CTRL_POLICY_LSB]);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign chif[g].fatal_in      = fatal_err[g];
      assign chif[g].policy        = policy;
      assign chif[g].in_op         = (state_r == ST_OP);
      assign chif[g].other_enabled = chan_enabled[1-g];
      // Error reset clears the latches, except when it is the trigger itself or is refused by the lock
      assign chif[g].clear         = reset_ok & ~(state_r == ST_OP && policy == POL_WAIT_RESET && any_latched);
      assign latched[g]            = chif[g].latched;
      assign wait_other[g]         = chif[g].wait_other;
      assign wait_reset[g]         = chif[g].wait_reset;
      assign disable_trig[g]       = chif[g].latched & ~chan_enabled[1-g];
      fatal_channel u_ch (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .ch      (chif[g])
      );
    end
  endgenerate

  assign any_latched = |latched;
  assign lock        = |wait_other;
  assign reset_ok    = reset_cmd & ~lock;

  always_comb begin
    unique case (policy)
      POL_WAIT_DISABLE: trig = |disable_trig;
      POL_WAIT_RESET:   trig = any_latched & reset_cmd;
      default:          trig = any_latched;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SAFE_OP: begin
        if (op_request && !any_latched && !(|fatal_err)) begin
          state_nxt = ST_OP;
        end
      end
      ST_OP: begin
        if (trig) begin
          state_nxt = ST_ERR_SAFE_OP;
        end
      end
      ST_ERR_SAFE_OP: begin
        // Cause must be gone, otherwise the latch would re-arm at once
        if (reset_ok && !(|fatal_err)) begin
          state_nxt = ST_OP;
        end
      end
      default: state_nxt = ST_SAFE_OP;
    endcase
  end

  always_comb begin
    ctrl_nxt    = ctrl_wr ? ctrl_wdata : ctrl_r;
    refused_nxt = reset_cmd & lock;
    stat_nxt[0] = status_of(wait_other[1], wait_other[0], wait_reset[0]);
    stat_nxt[1] = status_of(wait_other[0], wait_other[1], wait_reset[1]);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_SAFE_OP;
      ctrl_r    <= `CTRL_WORD_RESET;
      refused_r <= 1'b0;
      stat_r[0] <= `STAT_WORD_RESET;
      stat_r[1] <= `STAT_WORD_RESET;
    end else if (ce) begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt;
      refused_r <= refused_nxt;
      stat_r[0] <= stat_nxt[0];
      stat_r[1] <= stat_nxt[1];
    end
  end

  assign ctrl_rdata      = ctrl_r;
  assign status_word_0   = stat_r[0];
  assign status_word_1   = stat_r[1];
  assign reset_refused   = refused_r;
  assign comm_state      = state_r;
  assign comm_error_flag = (state_r == ST_ERR_SAFE_OP);
  assign actual_valid    = (state_r == ST_OP);
  // Shared comm unit: leaving Operational halts both axes
  assign axis_stop       = {2{state_r != ST_OP}};

  // Frozen cycles are skipped by sampling only when enabled
  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (!rstn);

  a_immediate_change: assert property (
    state_r == ST_OP && policy == POL_IMMEDIATE && any_latched |=> state_r == ST_ERR_SAFE_OP && comm_error_flag)
    else $error("immediate policy did not enter error safe-op");
  a_both_stopped: assert property (
    state_r == ST_ERR_SAFE_OP |-> axis_stop == 2'b11)
    else $error("an axis kept running in error safe-op");
  a_actuals_dropped: assert property (
    $rose(comm_error_flag) |-> !actual_valid && $past(actual_valid))
    else $error("actual values still valid in error safe-op");
  a_defer_disable: assert property (
    state_r == ST_OP && policy == POL_WAIT_DISABLE && !(|disable_trig) |=> state_r == ST_OP)
    else $error("deferred change happened with healthy channel enabled");
  a_reset_trigger: assert property (
    state_r == ST_OP && policy == POL_WAIT_RESET && any_latched |->
      if (reset_cmd) (##1 state_r == ST_ERR_SAFE_OP) else (##1 state_r == ST_OP))
    else $error("reset policy change not tied to reset command");
  a_bit0_mirror: assert property (
    1'b1 |=> status_word_0[0] == $past(wait_other[1]) && status_word_1[0] == $past(wait_other[0]))
    else $error("status bit 0 does not mirror the other channel");
  a_bit1_wait: assert property (
    state_r == ST_OP && policy == POL_WAIT_DISABLE && latched[1] && chan_enabled[0] |=> status_word_1[1])
    else $error("status bit 1 missing while waiting for disable");
  a_reset_locked: assert property (
    reset_cmd && lock |=> reset_refused && ($past(latched) & ~latched) == 2'b00)
    else $error("error reset accepted while locked");
  a_bit2_wait: assert property (
    state_r == ST_OP && policy == POL_WAIT_RESET && latched[0] |=> status_word_0[2])
    else $error("status bit 2 missing while waiting for reset");
  a_auto_return: assert property (
    state_r == ST_ERR_SAFE_OP && reset_cmd && !(|fatal_err) |=> state_r == ST_OP ##1 status_word_0[2:0] == 3'h0)
    else $error("no automatic return to operational");
  a_reserved_zero: assert property (
    status_word_0[15:3] == 13'h0000 && status_word_1[15:3] == 13'h0000)
    else $error("reserved status bits not zero");

  // A refused reset is a one-cycle echo of a locked request, nothing else
  a_refused_only: assert property (
    reset_refused |-> $past(reset_cmd) && $past(lock))
    else $error("refusal without a locked reset request");
  a_refused_quiet: assert property (
    !reset_cmd |=> !reset_refused)
    else $error("refusal raised without a reset request");
  a_pending_cleared: assert property (
    state_r != ST_OP |=> status_word_0[2:0] == 3'h0 && status_word_1[2:0] == 3'h0)
    else $error("pending bits kept outside operational");
  a_disable_trigger: assert property (
    state_r == ST_OP && policy == POL_WAIT_DISABLE && |disable_trig |=> state_r == ST_ERR_SAFE_OP)
    else $error("deferred change missed after channel disable");
  a_healthy_runs: assert property (
    state_r == ST_OP && policy == POL_WAIT_DISABLE && any_latched |-> axis_stop == 2'b00 && actual_valid)
    else $error("healthy channel stopped while change is deferred");
  a_reset_clears: assert property (
    state_r == ST_ERR_SAFE_OP && reset_cmd && !(|fatal_err) |=> latched == 2'b00)
    else $error("accepted error reset left a latch set");
  // The triggering reset must not also wipe the error it acts on
  a_reset_keeps_latch: assert property (
    state_r == ST_OP && policy == POL_WAIT_RESET && any_latched && reset_cmd |=> any_latched)
    else $error("triggering reset cleared the fatal latch");
  a_bit0_set: assert property (
    state_r == ST_OP && policy == POL_WAIT_DISABLE && latched[1] && chan_enabled[0] |=> status_word_0[0])
    else $error("status bit 0 missing for pending error of other channel");
  a_reserved_policy: assert property (
    state_r == ST_OP && policy == POL_RESERVED && any_latched |=> state_r == ST_ERR_SAFE_OP)
    else $error("reserved policy code did not change at once");
  a_ctrl_written: assert property (
    ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata))
    else $error("control word write not taken");

  c_immediate: cover property (state_r == ST_OP && policy == POL_IMMEDIATE ##1 state_r == ST_ERR_SAFE_OP);
  c_deferred:  cover property (status_word_0[1] ##[1:20] state_r == ST_ERR_SAFE_OP);
  c_by_reset:  cover property (status_word_1[2] ##[1:20] state_r == ST_ERR_SAFE_OP);
  c_refused:   cover property (reset_refused);
  c_recovery:  cover property (state_r == ST_ERR_SAFE_OP ##1 state_r == ST_OP);
endmodule : fatal_error_comm_ctrl

`default_nettype wire

/* sim/plc_master_model.sv */
/*
  Model of the fieldbus master and motion controller: writes the error
  reaction control word, requests Op and issues error reset pulses.
  Assumes ref_clk comes from the bench; all changes land on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module plc_master_model (
  input  wire logic        ref_clk,
  output logic             ctrl_wr,
  output logic [15:0]      ctrl_wdata,
  output logic             op_request,
  output logic             reset_cmd
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 16'hFFFF;
    op_request = 1'b0;
    reset_cmd = 1'b0;
  end

  task automatic write_ctrl(input logic [15:0] w);
    @(negedge ref_clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = w;
    @(negedge ref_clk);
    ctrl_wr = 1'b0;
    // Released data shows no stale word
    ctrl_wdata = ~w;
  endtask : write_ctrl

  task automatic pulse_op();
    @(negedge ref_clk);
    op_request = 1'b1;
    @(negedge ref_clk);
    op_request = 1'b0;
  endtask : pulse_op

  // Error reset is a one-cycle pulse, raised and dropped on falling edges
  task automatic issue_reset();
    @(negedge ref_clk);
    reset_cmd = 1'b1;
    @(negedge ref_clk);
    reset_cmd = 1'b0;
  endtask : issue_reset
endmodule : plc_master_model

`default_nettype wire

/* sim/fatal_error_comm_state_control_bench.sv */
/*
  Self-checking bench of the fatal error communication state control.
  Assumes the design package and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module fatal_error_comm_state_control_bench;
  import fatal_error_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn;
  logic        ce;
  logic [1:0]  fatal_err;
  logic [1:0]  chan_enabled;
  logic        ctrl_wr, op_request, reset_cmd, reset_refused;
  logic        comm_error_flag, actual_valid;
  logic [15:0] ctrl_wdata, ctrl_rdata, status_word_0, status_word_1;
  logic [1:0]  axis_stop;
  comm_state_t comm_state;
  int          miscompares = 0;
  int          num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  plc_master_model i_plc (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .op_request(op_request), .reset_cmd(reset_cmd));

  fatal_error_comm_ctrl #(.CHANNELS(2)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .status_word_0(status_word_0), .status_word_1(status_word_1), .fatal_err(fatal_err),
    .chan_enabled(chan_enabled), .op_request(op_request), .reset_cmd(reset_cmd),
    .reset_refused(reset_refused), .comm_state(comm_state), .comm_error_flag(comm_error_flag),
    .actual_valid(actual_valid), .axis_stop(axis_stop));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : step

  task automatic chk_state(input comm_state_t s, input logic [1:0] stop);
    check({14'h0000, comm_state}, {14'h0000, s});
    check({14'h0000, axis_stop}, {14'h0000, stop});
  endtask : chk_state

  // One-cycle fatal pulse; the channel latch must hold it
  task automatic fatal_blip(input logic [1:0] f);
    fatal_err = f;
    step(1);
    fatal_err = 2'b00;
    step(3);
  endtask : fatal_blip

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    #100us;
    miscompares++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    fatal_err = 2'b00;
    chan_enabled = 2'b11;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    check(status_word_0 | status_word_1 | ctrl_rdata, 16'h0000);
    chk_state(ST_SAFE_OP, 2'b11);
    // Frozen clock enable must ignore a write
    ce = 1'b0;
    i_plc.write_ctrl(16'h0002);
    check(ctrl_rdata, 16'h0000);
    ce = 1'b1;
    i_plc.write_ctrl(16'h0000);
    i_plc.pulse_op();
    chk_state(ST_OP, 2'b00);
    check({15'h0000, actual_valid}, 16'h0001);
    fatal_err = 2'b01;
    step(2);
    chk_state(ST_ERR_SAFE_OP, 2'b11);
    check({14'h0000, comm_error_flag, actual_valid}, 16'h0002);
    fatal_err = 2'b00;
    i_plc.issue_reset();
    chk_state(ST_OP, 2'b00);
    i_plc.write_ctrl(16'h0002);
    check(ctrl_rdata, 16'h0002);
    fatal_blip(2'b10);
    chk_state(ST_OP, 2'b00);
    check(status_word_1, 16'h0002);
    check(status_word_0, 16'h0001);
    i_plc.issue_reset();
    check({15'h0000, reset_refused}, 16'h0001);
    step(2);
    check(status_word_1, 16'h0002);
    chan_enabled = 2'b10;
    step(3);
    chk_state(ST_ERR_SAFE_OP, 2'b11);
    check(status_word_1 | status_word_0, 16'h0000);
    chan_enabled = 2'b11;
    i_plc.issue_reset();
    chk_state(ST_OP, 2'b00);
    i_plc.write_ctrl(16'h0004);
    fatal_blip(2'b01);
    chk_state(ST_OP, 2'b00);
    check(status_word_0, 16'h0004);
    i_plc.issue_reset();
    chk_state(ST_ERR_SAFE_OP, 2'b11);
    step(2);
    check(status_word_0, 16'h0000);
    i_plc.issue_reset();
    chk_state(ST_OP, 2'b00);
    // Reserved policy code falls back to the immediate change
    i_plc.write_ctrl(16'h0006);
    fatal_err = 2'b10;
    step(2);
    chk_state(ST_ERR_SAFE_OP, 2'b11);
    // Mid-run reset drops error state, policy and latches
    fatal_err = 2'b00;
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    chk_state(ST_SAFE_OP, 2'b11);
    check(ctrl_rdata | status_word_0 | status_word_1, 16'h0000);
    i_plc.pulse_op();
    chk_state(ST_OP, 2'b00);
    summarize();
  end
endmodule : fatal_error_comm_state_control_bench

`default_nettype wire
